/* hdl/an_base_page_pkg.sv */
// constants and types of the copper negotiation base-page register bank
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - next-page bit: software-driven versus automatic next pages
// - bit 13 sends remote fault to partner
// - bit 11 asymmetric pause, direction from bits 11 and 10
// - bit 10 advertises pause, resets to zero
// - bits 8, 7 advertise TX, hardware-set reset
// - selector field resets to 00001
// - partner page read-only, reset zero
// - complete flag follows the line complete input
// - parallel fault latches until register read
// - expansion bit 3 mirrors partner bit 15
// - expansion bit 2 always reads one
// - page received latches, cleared by read
// - bit 0 shows partner negotiation ability
package an_base_page_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] ADV_INDEX     = 16'hFFE4;
   localparam logic [15:0] PARTNER_INDEX = 16'hFFE5;
   localparam logic [15:0] EXP_INDEX     = 16'hFFE6;
   localparam logic [15:0] STATUS_INDEX  = 16'hFFE1;
   localparam logic [15:0] IRQ_STAT_INDEX = 16'hFFF0;
   localparam logic [15:0] IRQ_EN_INDEX   = 16'hFFF1;
   localparam logic [15:0] IRQ_CLR_INDEX  = 16'hFFF2;
   // ****************************************
   // field positions
   // ****************************************
   localparam int NEXT_PAGE_BIT   = 15;
   localparam int ACK_BIT         = 14;
   localparam int REMOTE_BIT      = 13;
   localparam int TECH_BIT        = 12;
   localparam int ASYM_BIT        = 11;
   localparam int PAUSE_BIT       = 10;
   localparam int T4_BIT          = 9;
   localparam int TX_FULL_BIT     = 8;
   localparam int TX_HALF_BIT     = 7;
   localparam int COMPLETE_BIT    = 5;
   localparam int PD_FAULT_BIT    = 4;
   localparam int PARTNER_NP_BIT  = 3;
   localparam int LOCAL_NP_BIT    = 2;
   localparam int PAGE_RX_BIT     = 1;
   localparam int PARTNER_AN_BIT  = 0;
   localparam logic [15:0] ADV_WRITE_MASK  = 16'hEFFF;
   localparam logic [15:0] PARTNER_MASK    = 16'hEF9F;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] ADV_RESET       = 16'h1001;
   localparam logic [15:0] PARTNER_RESET   = 16'h0000;
   localparam logic [2:0]  IRQ_EN_RESET    = 3'h0;
   // interrupt status bit order: page received, fault, complete
   localparam int IRQ_PAGE_BIT     = 0;
   localparam int IRQ_FAULT_BIT    = 1;
   localparam int IRQ_COMPLETE_BIT = 2;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        page_valid;
      logic [15:0] page;
      logic        pd_fault;
      logic        complete;
      logic        partner_able;
   } line_in_type;

   typedef struct packed {
      logic [15:0] adv;
      logic        sw_next_page;
      logic        auto_next_page;
      logic        send_remote_fault;
      logic        pause_toward_local;
   } line_out_type;

   function automatic logic [31:0] byte_addr(input logic [15:0] index);
      byte_addr = {14'h0000, index, 2'h0};
   endfunction
endpackage

/* hdl/an_event_latch.sv */
// sticky flag array, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module an_event_latch #(
   parameter int WIDTH = 3
) (
   input  wire logic             CLK,
   input  wire logic             ARST_N,
   input  wire logic [WIDTH-1:0] SET,
   input  wire logic [WIDTH-1:0] CLEAR,
   output var  logic [WIDTH-1:0] FLAGS
);
   typedef struct packed {
      logic [WIDTH-1:0] flags_q;
   } state_type;
   state_type s_q;
   state_type s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < WIDTH; i++) begin
         s_d.flags_q[i] = SET[i] | (s_q.flags_q[i] & ~CLEAR[i]);
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign FLAGS = s_q.flags_q;
endmodule
`default_nettype wire

/* hdl/an_base_page_regs.sv */
// apb register bank for negotiation base pages
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module an_base_page_regs (
   input  wire logic                        CLK,
   input  wire logic                        ARST_N,
   input  wire an_base_page_pkg::apb_req_type APB_REQ,
   output var  logic                        PREADY,
   output var  logic [31:0]                 PRDATA,
   output var  logic                        PSLVERR,
   input  wire an_base_page_pkg::line_in_type LINE_IN,
   input  wire logic                        TX_FULL_STRAP,
   input  wire logic                        TX_HALF_STRAP,
   input  wire logic                        ADV_1000T,
   output var  an_base_page_pkg::line_out_type LINE_OUT,
   output var  logic                        IRQ
);
   import an_base_page_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0] adv_q;
      logic [15:0] partner_q;
      logic        complete_q;
      logic        partner_able_q;
      logic        straps_taken_q;
      logic [2:0]  irq_en_q;
      logic [31:0] rdata_q;
      logic        slverr_q;
      logic        irq_q;
   } state_type;
   state_type s_q;
   state_type s_d;

   logic        access;
   logic        wr;
   logic        rd;
   logic [15:0] index;
   logic        mapped;
   logic [1:0]  exp_set;
   logic [1:0]  exp_clr;
   logic [1:0]  exp_flags;
   logic [2:0]  irq_set;
   logic [2:0]  irq_clr;
   logic [2:0]  irq_flags;
   logic [15:0] exp_word;
   logic        complete_rise;

   function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
      hit = (addr == byte_addr(idx));
   endfunction

   // ****************************************
   // bus decode
   // ****************************************
   assign access = APB_REQ.psel & APB_REQ.penable;
   assign wr     = access & APB_REQ.pwrite;
   assign rd     = access & ~APB_REQ.pwrite;
   assign index  = APB_REQ.paddr[17:2];
   assign mapped = (APB_REQ.paddr[31:18] == 14'h0000) && (APB_REQ.paddr[1:0] == 2'h0) &&
                   (index == ADV_INDEX || index == PARTNER_INDEX || index == EXP_INDEX ||
                    index == STATUS_INDEX || index == IRQ_STAT_INDEX || index == IRQ_EN_INDEX ||
                    index == IRQ_CLR_INDEX);

   // ****************************************
   // latched expansion and interrupt flags
   // ****************************************
   assign exp_set[0] = LINE_IN.page_valid;
   assign exp_set[1] = LINE_IN.pd_fault;
   assign exp_clr[0] = rd & hit(APB_REQ.paddr, EXP_INDEX);
   assign exp_clr[1] = rd & hit(APB_REQ.paddr, EXP_INDEX);

   an_event_latch #(.WIDTH(2)) u_exp_latch (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .SET    (exp_set),
      .CLEAR  (exp_clr),
      .FLAGS  (exp_flags)
   );

   assign complete_rise = LINE_IN.complete & ~s_q.complete_q;
   assign irq_set[IRQ_PAGE_BIT]     = LINE_IN.page_valid;
   assign irq_set[IRQ_FAULT_BIT]    = LINE_IN.pd_fault;
   assign irq_set[IRQ_COMPLETE_BIT] = complete_rise;
   assign irq_clr = (wr && hit(APB_REQ.paddr, IRQ_CLR_INDEX)) ? APB_REQ.pwdata[2:0] : 3'h0;

   an_event_latch #(.WIDTH(3)) u_irq_latch (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .SET    (irq_set),
      .CLEAR  (irq_clr),
      .FLAGS  (irq_flags)
   );

   always_comb begin
      exp_word = 16'h0000;
      exp_word[PD_FAULT_BIT]   = exp_flags[1];
      exp_word[PARTNER_NP_BIT] = s_q.partner_q[NEXT_PAGE_BIT];
      exp_word[LOCAL_NP_BIT]   = 1'b1;
      exp_word[PAGE_RX_BIT]    = exp_flags[0];
      exp_word[PARTNER_AN_BIT] = s_q.partner_able_q;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.complete_q     = LINE_IN.complete;
      s_d.partner_able_q = LINE_IN.partner_able;
      s_d.irq_q          = |(irq_flags & s_q.irq_en_q);
      if (!s_q.straps_taken_q) begin
         s_d.straps_taken_q          = 1'b1;
         s_d.adv_q[TX_FULL_BIT]      = TX_FULL_STRAP;
         s_d.adv_q[TX_HALF_BIT]      = TX_HALF_STRAP;
      end
      if (LINE_IN.page_valid) begin
         s_d.partner_q = LINE_IN.page & PARTNER_MASK;
      end
      if (wr && hit(APB_REQ.paddr, ADV_INDEX)) begin
         s_d.adv_q = (APB_REQ.pwdata[15:0] & ADV_WRITE_MASK) | ADV_RESET & ~ADV_WRITE_MASK;
      end
      if (wr && hit(APB_REQ.paddr, IRQ_EN_INDEX)) begin
         s_d.irq_en_q = APB_REQ.pwdata[2:0];
      end
      s_d.slverr_q = access & ~mapped;
      s_d.rdata_q  = 32'h0000_0000;
      if (rd) begin
         case (index)
            ADV_INDEX:      s_d.rdata_q = {16'h0000, s_q.adv_q};
            PARTNER_INDEX:  s_d.rdata_q = {16'h0000, s_q.partner_q};
            EXP_INDEX:      s_d.rdata_q = {16'h0000, exp_word};
            STATUS_INDEX:   s_d.rdata_q = {26'h0, s_q.complete_q, 5'h00};
            IRQ_STAT_INDEX: s_d.rdata_q = {29'h0, irq_flags};
            IRQ_EN_INDEX:   s_d.rdata_q = {29'h0, s_q.irq_en_q};
            default:        s_d.rdata_q = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q <= '0;
         s_q.adv_q <= ADV_RESET;
         s_q.partner_q <= PARTNER_RESET;
         s_q.irq_en_q <= IRQ_EN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // read data is decoded combinationally and presented in the access cycle itself
   assign PREADY  = APB_REQ.psel & APB_REQ.penable;
   assign PRDATA  = rd ? s_d.rdata_q : 32'h0000_0000;
   assign PSLVERR = access & ~mapped;
   assign IRQ     = s_q.irq_q;

   always_comb begin
      LINE_OUT                    = '0;
      LINE_OUT.adv                = s_q.adv_q;
      LINE_OUT.sw_next_page       = s_q.adv_q[NEXT_PAGE_BIT];
      LINE_OUT.auto_next_page     = ~s_q.adv_q[NEXT_PAGE_BIT] & ADV_1000T;
      LINE_OUT.send_remote_fault  = s_q.adv_q[REMOTE_BIT];
      LINE_OUT.pause_toward_local = s_q.adv_q[ASYM_BIT] & s_q.adv_q[PAUSE_BIT];
   end
endmodule
`default_nettype wire

/* bench/an_line_model.sv */
// line-side negotiation engine model
`timescale 1ns/100ps
`default_nettype none
module an_line_model import an_base_page_pkg::*; (
   input  wire logic                          CLK,
   output var  an_base_page_pkg::line_in_type LINE_IN
);
   initial LINE_IN = '0;
   task automatic send(input logic [15:0] p);
      LINE_IN.page       <= p;
      LINE_IN.page_valid <= 1'b1;
      @(posedge CLK);
      LINE_IN.page       <= ~p;
      LINE_IN.page_valid <= 1'b0;
   endtask
   task automatic fault();
      LINE_IN.pd_fault <= 1'b1;
      @(posedge CLK);
      LINE_IN.pd_fault <= 1'b0;
   endtask
   task automatic lvl(input logic c, input logic a);
      LINE_IN.complete     <= c;
      LINE_IN.partner_able <= a;
   endtask
endmodule
`default_nettype wire

/* bench/an_base_page_regs_sva.sv */
// property checker for the negotiation register bank
`timescale 1ns/100ps
`default_nettype none
module an_base_page_regs_sva import an_base_page_pkg::*; (
   input wire logic                           CLK,
   input wire logic                           ARST_N,
   input wire an_base_page_pkg::apb_req_type  APB_REQ,
   input wire logic                           PREADY,
   input wire logic [31:0]                    PRDATA,
   input wire logic                           PSLVERR,
   input wire an_base_page_pkg::line_in_type  LINE_IN,
   input wire logic                           TX_FULL_STRAP,
   input wire logic                           TX_HALF_STRAP,
   input wire logic                           ADV_1000T,
   input wire an_base_page_pkg::line_out_type LINE_OUT,
   input wire logic                           IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   logic rd, rd_exp, rd_adv, rd_par;
   assign rd     = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
   assign rd_exp = rd && APB_REQ.paddr == {14'h0000, EXP_INDEX, 2'h0};
   assign rd_adv = rd && APB_REQ.paddr == {14'h0000, ADV_INDEX, 2'h0};
   assign rd_par = rd && APB_REQ.paddr == {14'h0000, PARTNER_INDEX, 2'h0};
   property p_np; LINE_OUT.auto_next_page == (!LINE_OUT.adv[15] && ADV_1000T); endproperty
   a_np: assert property (p_np) else $error("next page mode");
   property p_rf; LINE_OUT.send_remote_fault == LINE_OUT.adv[13]; endproperty
   a_rf: assert property (p_rf) else $error("remote fault");
   property p_dir; LINE_OUT.pause_toward_local == (LINE_OUT.adv[11] && LINE_OUT.adv[10]); endproperty
   a_dir: assert property (p_dir) else $error("pause direction");
   property p_tech; LINE_OUT.adv[12] && LINE_OUT.sw_next_page == LINE_OUT.adv[15]; endproperty
   a_tech: assert property (p_tech) else $error("tech bit");
   property p_adv; rd_adv |-> PRDATA == {16'h0000, LINE_OUT.adv}; endproperty
   a_adv: assert property (p_adv) else $error("adv read");
   property p_par; rd_par |-> (PRDATA & ~{16'h0000, PARTNER_MASK}) == 32'h0000_0000; endproperty
   a_par: assert property (p_par) else $error("partner read");
   property p_ro; rd_exp |-> PRDATA[15:5] == 11'h000 && PRDATA[2]; endproperty
   a_ro: assert property (p_ro) else $error("fixed bits");
   property p_flt; LINE_IN.pd_fault ##1 !rd_exp ##1 rd_exp |-> PRDATA[4]; endproperty
   a_flt: assert property (p_flt) else $error("fault flag");
   property p_clr; (rd_exp && !LINE_IN.page_valid) ##3 (rd_exp && !$past(LINE_IN.page_valid)
      && !$past(LINE_IN.page_valid, 2)) |-> !PRDATA[1]; endproperty
   a_clr: assert property (p_clr) else $error("page clear");
   property p_keep; (rd_exp && LINE_IN.page_valid) ##3 rd_exp |-> PRDATA[1]; endproperty
   a_keep: assert property (p_keep) else $error("page kept");
endmodule
bind an_base_page_regs an_base_page_regs_sva u_an_base_page_regs_sva (.CLK(CLK), .ARST_N(ARST_N),
   .APB_REQ(APB_REQ), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .LINE_IN(LINE_IN),
   .TX_FULL_STRAP(TX_FULL_STRAP), .TX_HALF_STRAP(TX_HALF_STRAP), .ADV_1000T(ADV_1000T),
   .LINE_OUT(LINE_OUT), .IRQ(IRQ));
`default_nettype wire

/* bench/an_base_page_regs_tb_top.sv */
// self-checking bench for the negotiation register bank
`timescale 1ns/100ps
`default_nettype none
module an_base_page_regs_tb_top;
   import an_base_page_pkg::*;
   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   logic         tx_full = 1'b1;
   logic         tx_half = 1'b0;
   logic         adv_1000t = 1'b1;
   apb_req_type  req = '0;
   logic         pready, pslverr, irq, e;
   logic [31:0]  prdata, q;
   line_in_type  line_in;
   line_out_type line_out;
   int           error_cnt = 0;
   int           total_checks = 0;
   int           cyc = 0;
   always #25 clk = ~clk;
   an_base_page_regs u_an_base_page_regs (.CLK(clk), .ARST_N(arst_n), .APB_REQ(req), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .LINE_IN(line_in), .TX_FULL_STRAP(tx_full),
      .TX_HALF_STRAP(tx_half), .ADV_1000T(adv_1000t), .LINE_OUT(line_out), .IRQ(irq));
   an_line_model u_an_line_model (.CLK(clk), .LINE_IN(line_in));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, {14'h0000, a, 2'h0}, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rx(input logic [15:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000);
      chk(q, x);
   endtask
   task automatic irqchk(input logic x);
      repeat (2) @(negedge clk);
      chk(32'(irq), 32'(x));
      @(posedge clk);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rx(ADV_INDEX, 32'h0000_1101);
      rx(PARTNER_INDEX, 32'h0000_0000);
      rx(EXP_INDEX, 32'h0000_0004);
      $display("reset test done");
      xfer(1'b1, ADV_INDEX, 32'h0000_BD61);
      rx(ADV_INDEX, 32'h0000_BD61);
      chk(32'({line_out.sw_next_page, line_out.send_remote_fault, line_out.pause_toward_local}), 32'h7);
      xfer(1'b1, ADV_INDEX, {16'h0000, (q[15:0] & 16'h4060) | 16'h1401});
      rx(ADV_INDEX, 32'h0000_1461);
      chk(32'({line_out.auto_next_page, line_out.pause_toward_local}), 32'h2);
      adv_1000t <= 1'b0;
      @(posedge clk);
      chk(32'(line_out.auto_next_page), 32'h0000_0000);
      $display("advert test done");
      u_an_line_model.lvl(1'b1, 1'b1);
      u_an_line_model.send(16'hFFFF);
      rx(PARTNER_INDEX, 32'h0000_EF9F);
      rx(STATUS_INDEX, 32'h0000_0020);
      rx(EXP_INDEX, 32'h0000_000F);
      rx(EXP_INDEX, 32'h0000_000D);
      u_an_line_model.fault();
      rx(EXP_INDEX, 32'h0000_001D);
      rx(EXP_INDEX, 32'h0000_000D);
      fork
         rx(EXP_INDEX, 32'h0000_000D);
         begin
            @(posedge clk);
            u_an_line_model.send(16'h0001);
         end
      join
      rx(EXP_INDEX, 32'h0000_0007);
      $display("flag test done");
      xfer(1'b1, PARTNER_INDEX, 32'h0000_FFFF);
      rx(PARTNER_INDEX, 32'h0000_0001);
      xfer(1'b0, 16'h0100, 32'h0000_0000);
      chk({q[30:0], e}, 32'h0000_0001);
      xfer(1'b1, IRQ_EN_INDEX, 32'h0000_0001);
      xfer(1'b1, IRQ_CLR_INDEX, 32'h0000_0007);
      irqchk(1'b0);
      u_an_line_model.send(16'h0001);
      irqchk(1'b1);
      rx(IRQ_STAT_INDEX, 32'h0000_0001);
      xfer(1'b1, IRQ_CLR_INDEX, 32'h0000_0001);
      irqchk(1'b0);
      xfer(1'b1, IRQ_EN_INDEX, 32'h0000_0000);
      u_an_line_model.send(16'h0001);
      irqchk(1'b0);
      rx(IRQ_STAT_INDEX, 32'h0000_0001);
      $display("access test done");
      tx_full <= 1'b0;
      tx_half <= 1'b1;
      arst_n  <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rx(ADV_INDEX, 32'h0000_1081);
      rx(PARTNER_INDEX, 32'h0000_0000);
      $display("second reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
